//--- rtl/qpc_pkg.sv
package qpc_pkg;
  // Byte addresses of the base registers; each has clear/set/invert aliases
  localparam logic [15:0] OFS_CONTROL = 16'hB600;
  localparam logic [15:0] OFS_POSITION = 16'hB630;
  localparam logic [15:0] OFS_POSITION_HOLD = 16'hB640;
  localparam logic [15:0] OFS_VELOCITY = 16'hB650;
  localparam logic [15:0] OFS_VELOCITY_HOLD = 16'hB660;
  localparam logic [15:0] OFS_INTERVAL = 16'hB670;
  localparam logic [15:0] OFS_INTERVAL_HOLD = 16'hB680;
  localparam logic [15:0] OFS_INDEX = 16'hB690;
  localparam logic [15:0] OFS_INDEX_HOLD = 16'hB6A0;
  localparam logic [15:0] OFS_ICC = 16'hB6B0;
  localparam logic [15:0] OFS_LOWER_CMP = 16'hB6C0;
  // Alias selector in address bits 3:2
  localparam logic [1:0] ALIAS_PLAIN = 2'h0;
  localparam logic [1:0] ALIAS_CLR = 2'h1;
  localparam logic [1:0] ALIAS_SET = 2'h2;
  localparam logic [1:0] ALIAS_INV = 2'h3;
  // Control register fields
  localparam int CON_RUN_BIT = 15;
  localparam int CON_IDLE_BIT = 13;
  localparam int CON_POSITION_INIT_MODE_LSB = 10;
  localparam int CON_IMV_LSB = 8;
  localparam int CON_PRESCALE_LSB = 4;
  localparam int CON_POL_BIT = 3;
  localparam int CON_GATE_BIT = 2;
  localparam int CON_CCM_LSB = 0;
  localparam logic [31:0] CON_IMPL_MASK = 32'h0000_BF7F;
  localparam logic [31:0] REG_RESET = 32'h0000_0000;
  // Counter control modes
  localparam logic [1:0] CCM_QUAD_X4 = 2'h0;
  localparam logic [1:0] CCM_CLK_DIR = 2'h1;
  localparam logic [1:0] CCM_CLK_GATE = 2'h2;
  localparam logic [1:0] CCM_TIMER = 2'h3;
  // Position initialisation modes
  localparam logic [2:0] PIM_NONE = 3'h0;
  localparam logic [2:0] PIM_IDX_RESET = 3'h1;
  localparam logic [2:0] PIM_NEXT_IDX_LOAD = 3'h2;
  localparam logic [2:0] PIM_HOME_IDX1_LOAD = 3'h3;
  localparam logic [2:0] PIM_HOME_IDX2_LOAD = 3'h4;
  localparam logic [2:0] PIM_EQ_RESET = 3'h5;
  localparam logic [2:0] PIM_MODULO = 3'h6;
  localparam logic [2:0] PIM_MODULO_IDX = 3'h7;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : qpc_pkg

//--- rtl/qpc_top.sv
// Local design decision: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module qpc_top
  import qpc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [15:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [15:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic phase_a_input,
  input wire logic phase_b_input,
  input wire logic index_input,
  input wire logic home_input,
  input wire logic device_idle
);

  localparam int NREG = 11;
  localparam logic [15:0] REG_OFS [NREG] = '{OFS_CONTROL, OFS_POSITION, OFS_POSITION_HOLD,
    OFS_VELOCITY, OFS_VELOCITY_HOLD, OFS_INTERVAL, OFS_INTERVAL_HOLD, OFS_INDEX,
    OFS_INDEX_HOLD, OFS_ICC, OFS_LOWER_CMP};
  localparam int R_CON = 0;
  localparam int R_POS = 1;
  localparam int R_VEL = 3;
  localparam int R_ITMR = 5;
  localparam int R_IDX = 7;
  localparam int R_ICC = 9;
  localparam int R_CMPL = 10;
  logic [31:0] regs [NREG];

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers and event pulses

  logic [3:0] sync1;
  logic [3:0] sync2;
  logic [3:0] sync3;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1 <= 4'h0;
      sync2 <= 4'h0;
      sync3 <= 4'h0;
    end else begin
      sync1 <= {home_input, index_input, phase_b_input, phase_a_input};
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  logic pa;
  logic pb;
  logic pa_prev;
  logic pb_prev;
  logic idx_rise;
  logic home_evt;
  assign pa = sync2[0];
  assign pb = sync2[1];
  assign pa_prev = sync3[0];
  assign pb_prev = sync3[1];
  assign idx_rise = sync2[2] & ~sync3[2];
  assign home_evt = sync2[3] & ~sync3[3];

  ////////////////////////////////////////////////////////////////////////////
  // Control decode

  logic run;
  logic [2:0] position_init_mode;
  logic [1:0] counter_control_mode;
  logic [1:0] index_match_value;
  logic cnt_pol;
  logic gate_en;
  logic idx_evt;
  assign position_init_mode = regs[R_CON][CON_POSITION_INIT_MODE_LSB +: 3];
  assign counter_control_mode = regs[R_CON][CON_CCM_LSB +: 2];
  assign index_match_value = regs[R_CON][CON_IMV_LSB +: 2];
  assign cnt_pol = regs[R_CON][CON_POL_BIT];
  assign gate_en = regs[R_CON][CON_GATE_BIT];
  assign run = regs[R_CON][CON_RUN_BIT] & ~(regs[R_CON][CON_IDLE_BIT] & device_idle);
  // Index only counts when phase levels match the programmed value
  assign idx_evt = idx_rise & ({pb, pa} == index_match_value);

  ////////////////////////////////////////////////////////////////////////////
  // Count step per mode

  logic step;
  logic step_up;
  logic quad_edge;
  always_comb begin
    quad_edge = (pa ^ pa_prev) ^ (pb ^ pb_prev);
    step = 1'b0;
    step_up = ~cnt_pol;
    case (counter_control_mode)
      CCM_QUAD_X4: begin
        step = quad_edge;
        step_up = (pb_prev ^ pa) ^ cnt_pol;
      end
      CCM_CLK_DIR: begin
        step = pa & ~pa_prev;
        step_up = pb;
      end
      CCM_CLK_GATE: step = (pa & ~pa_prev) & (~gate_en | pb);
      CCM_TIMER: step = ~gate_en | pb;
      default: step = 1'b0;
    endcase
    step = step & run;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Position initialisation state

  logic home_seen;
  logic idx_once;
  logic next_armed;
  logic init_load;

  always_comb begin
    init_load = 1'b0;
    if (run && counter_control_mode == CCM_QUAD_X4 && idx_evt) begin
      case (position_init_mode)
        PIM_NEXT_IDX_LOAD: init_load = next_armed;
        PIM_HOME_IDX1_LOAD: init_load = home_seen;
        PIM_HOME_IDX2_LOAD: init_load = home_seen & idx_once;
        default: init_load = 1'b0;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      home_seen <= 1'b0;
      idx_once <= 1'b0;
      next_armed <= 1'b1;
    end else begin
      // Re-arm whenever another mode is selected so 010 acts on the next index
      next_armed <= (position_init_mode != PIM_NEXT_IDX_LOAD) | (next_armed & ~init_load);
      if (home_evt) begin
        home_seen <= 1'b1;
        idx_once <= 1'b0;
      end else if (init_load) begin
        home_seen <= 1'b0;
        idx_once <= 1'b0;
      end else if (run && idx_evt && home_seen) begin
        idx_once <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Position counter next value

  logic [31:0] next_pos;
  logic [31:0] pos;
  logic [31:0] icc;
  logic [31:0] cmpl;
  logic modulo;
  assign pos = regs[R_POS];
  assign icc = regs[R_ICC];
  assign cmpl = regs[R_CMPL];
  assign modulo = counter_control_mode == CCM_QUAD_X4 && (position_init_mode == PIM_MODULO || position_init_mode == PIM_MODULO_IDX);

  always_comb begin
    next_pos = pos;
    if (step) begin
      if (modulo && step_up && pos == icc) begin
        next_pos = cmpl;
      end else if (modulo && !step_up && pos == cmpl) begin
        next_pos = icc;
      end else begin
        next_pos = step_up ? pos + 32'h0000_0001 : pos - 32'h0000_0001;
      end
    end
    // Init modes act only in quadrature mode; timers ignore them
    if (run && counter_control_mode == CCM_QUAD_X4) begin
      case (position_init_mode)
        PIM_IDX_RESET: if (idx_evt) next_pos = 32'h0000_0000;
        PIM_MODULO_IDX: if (idx_evt) next_pos = 32'h0000_0000;
        PIM_EQ_RESET: if (pos == icc) next_pos = 32'h0000_0000;
        PIM_NONE: next_pos = next_pos;
        default: if (init_load) next_pos = icc;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave

  logic wr_fire;
  logic rd_fire;
  logic wr_hit;
  logic [3:0] wr_sel;
  logic [1:0] wr_alias;
  logic [31:0] wr_mask;
  logic [31:0] rd_word;
  logic rd_hit;

  assign wr_fire = s_axi_awvalid & s_axi_wvalid & ~s_axi_awready & ~s_axi_bvalid;
  assign rd_fire = s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
  assign wr_alias = s_axi_awaddr[3:2];
  assign wr_mask = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}}, {8{s_axi_wstrb[1]}},
    {8{s_axi_wstrb[0]}}};

  always_comb begin
    wr_hit = 1'b0;
    wr_sel = 4'h0;
    rd_hit = 1'b0;
    rd_word = 32'h0000_0000;
    for (int i = 0; i < NREG; i++) begin
      if (s_axi_awaddr[15:4] == REG_OFS[i][15:4] && s_axi_awaddr[1:0] == 2'h0) begin
        wr_hit = 1'b1;
        wr_sel = i[3:0];
      end
      if (s_axi_araddr == REG_OFS[i]) begin
        rd_hit = 1'b1;
        rd_word = regs[i];
      end
    end
  end

  // Alias write: strobes select bits; clr/set/inv use the data as a bit mask
  function automatic logic [31:0] qpc_apply(input logic [31:0] old, input logic [1:0] alias_sel,
                                            input logic [31:0] data, input logic [31:0] lanes);
    logic [31:0] m;
    m = data & lanes;
    case (alias_sel)
      ALIAS_CLR: qpc_apply = old & ~m;
      ALIAS_SET: qpc_apply = old | m;
      ALIAS_INV: qpc_apply = old ^ m;
      default: qpc_apply = (old & ~lanes) | m;
    endcase
  endfunction : qpc_apply
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      s_axi_awready <= wr_fire;
      s_axi_wready <= wr_fire;
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      s_axi_arready <= rd_fire;
      if (rd_fire) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register file; a software write wins over the counter update in that cycle

  logic [31:0] next_regs [NREG];
  always_comb begin
    for (int i = 0; i < NREG; i++) begin
      next_regs[i] = regs[i];
    end
    next_regs[R_POS] = next_pos;
    if (step) begin
      next_regs[R_VEL] = step_up ? regs[R_VEL] + 32'h0000_0001 : regs[R_VEL] - 32'h0000_0001;
    end
    if (run) begin
      next_regs[R_ITMR] = regs[R_ITMR] + 32'h0000_0001;
    end
    if (run && idx_evt) begin
      next_regs[R_IDX] = (cnt_pol ? regs[R_IDX] - 32'h0000_0001
                                  : regs[R_IDX] + 32'h0000_0001);
    end
    if (wr_fire && wr_hit) begin
      next_regs[wr_sel] = qpc_apply(regs[wr_sel], wr_alias, s_axi_wdata, wr_mask);
    end
    next_regs[R_CON] = next_regs[R_CON] & CON_IMPL_MASK;
  end

  always_ff @(posedge aclk) begin
    for (int i = 0; i < NREG; i++) begin
      if (!aresetn) begin
        regs[i] <= REG_RESET;
      end else begin
        regs[i] <= next_regs[i];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  logic sw_pos_wr;
  assign sw_pos_wr = wr_fire & wr_hit & (wr_sel == R_POS[3:0]);
  sequence seq_wr_taken;
    wr_fire ##1 (s_axi_awready && s_axi_wready);
  endsequence

  sequence seq_resp;
    s_axi_bvalid [*1];
  endsequence

  AST_WRITE_RESP: assert property (seq_wr_taken |-> ##0 seq_resp)
    else $error("write response missing after handshake");

  AST_SET_ALIAS: assert property (wr_fire && wr_hit && wr_alias == ALIAS_SET
      && wr_sel == R_ICC[3:0] && s_axi_wstrb == 4'hF
      |=> (regs[R_ICC] & $past(s_axi_wdata)) == $past(s_axi_wdata))
    else $error("set alias did not set bits");

  AST_CLR_ALIAS: assert property (wr_fire && wr_hit && wr_alias == ALIAS_CLR
      && wr_sel == R_ICC[3:0] && s_axi_wstrb == 4'hF
      |=> (regs[R_ICC] & $past(s_axi_wdata)) == 32'h0000_0000)
    else $error("clear alias did not clear bits");

  AST_STOPPED: assert property (!regs[R_CON][CON_RUN_BIT] && !sw_pos_wr
      |=> regs[R_POS] == $past(regs[R_POS]))
    else $error("position moved while disabled");

  AST_IDLE_HALT: assert property (regs[R_CON][CON_IDLE_BIT] && device_idle
      && !(wr_fire && wr_hit && wr_sel == R_ITMR[3:0])
      |=> $stable(regs[R_ITMR]))
    else $error("interval timer ran while idle halted");

  AST_CON_ZERO: assert property ((regs[R_CON] & ~CON_IMPL_MASK) == 32'h0000_0000)
    else $error("unimplemented control bits set");

  AST_IDX_RESET: assert property (run && counter_control_mode == CCM_QUAD_X4 && idx_evt && !sw_pos_wr
      && (position_init_mode == PIM_IDX_RESET || position_init_mode == PIM_MODULO_IDX)
      |=> regs[R_POS] == 32'h0000_0000)
    else $error("index did not reset position");

  AST_EQ_RESET: assert property (run && counter_control_mode == CCM_QUAD_X4 && position_init_mode == PIM_EQ_RESET
      && pos == icc && !sw_pos_wr |=> regs[R_POS] == 32'h0000_0000)
    else $error("equal compare did not reset position");

  AST_X4_STEP: assert property (run && counter_control_mode == CCM_QUAD_X4 && position_init_mode == PIM_NONE
      && quad_edge && !sw_pos_wr
      |=> regs[R_POS] - $past(regs[R_POS]) == ($past(step_up) ? 32'h0000_0001
                                                              : 32'hFFFF_FFFF))
    else $error("x4 step wrong");

  AST_TIMER_MODE: assert property (run && counter_control_mode == CCM_TIMER && !gate_en && !modulo
      && !sw_pos_wr |=> regs[R_POS] != $past(regs[R_POS]))
    else $error("timer mode did not count");

endmodule : qpc_top
`default_nettype wire

//--- testbench/qpc_encoder_model.sv
`timescale 1ns/1ps
`default_nettype none
module qpc_encoder_model (
  input wire logic aclk,
  output logic phase_a,
  output logic phase_b,
  output var logic index_out,
  output var logic home_out
);
  // Gray position: 00, 01, 11, 10 with A leading B when moving up
  logic [1:0] slot = 2'h0;
  assign phase_a = slot[1] ^ slot[0];
  assign phase_b = slot[1];
  initial begin
    index_out = 1'b0;
    home_out = 1'b0;
  end
  ////////////////////////////////////////
  task automatic step(input bit up);
    @(posedge aclk);
    slot <= up ? slot + 2'h1 : slot - 2'h1;
    repeat (4) @(posedge aclk);
  endtask : step
  task automatic pulse(input bit home);
    @(posedge aclk);
    if (home) home_out <= 1'b1;
    else index_out <= 1'b1;
    repeat (4) @(posedge aclk);
    home_out <= 1'b0;
    index_out <= 1'b0;
    repeat (4) @(posedge aclk);
  endtask : pulse
endmodule : qpc_encoder_model
`default_nettype wire

//--- testbench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import qpc_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [15:0] awaddr = 16'h0000, araddr = 16'h0000;
  logic [31:0] wdata = 32'h0000_0000, rdata, rv, pos, icc, m;
  logic [3:0] wstrb = 4'hF;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, pa, pb, idx, home;
  logic [1:0] bresp, rresp, rs, index_match_value, lv;
  logic device_idle = 1'b0;
  logic [15:0] regs [11] = '{OFS_CONTROL, OFS_POSITION, OFS_POSITION_HOLD, OFS_VELOCITY,
    OFS_VELOCITY_HOLD, OFS_INTERVAL, OFS_INTERVAL_HOLD, OFS_INDEX, OFS_INDEX_HOLD, OFS_ICC,
    OFS_LOWER_CMP};
  localparam logic [31:0] RUN = 32'h0000_8000;
  int miscompares = 0;
  int num_checks = 0;
  int pm;
  int nidx = 0;
  initial forever #20 aclk = ~aclk;
  qpc_top i_qpc_top (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .phase_a_input(pa), .phase_b_input(pb), .index_input(idx), .home_input(home),
    .device_idle(device_idle));
  qpc_encoder_model i_qpc_encoder_model (.aclk(aclk), .phase_a(pa), .phase_b(pb),
    .index_out(idx), .home_out(home));
  ////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
      miscompares++;
    end
  endtask : chk
  // Waits for the answer with no limit of its own; the watchdog ends a hang
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    rs = bresp;
    bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [15:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rv = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask : rd
  task automatic steps(input int k, input bit up);
    repeat (k) i_qpc_encoder_model.step(up);
  endtask : steps
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : summarize
  ////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge aclk);
    miscompares++;
    summarize();
  end
  initial begin
    void'($urandom(45));
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (regs[i]) begin
      rd(regs[i]);
      chk("reset value", REG_RESET, rv);
    end
    wr(OFS_CONTROL, 32'hFFFF_FFFF);
    rd(OFS_CONTROL);
    chk("control readback", CON_IMPL_MASK, rv);
    $display("test reset_and_mask done");
    icc = $urandom();
    wr(OFS_ICC, icc);
    for (int k = 1; k < 4; k++) begin
      m = $urandom();
      wr(OFS_ICC + 16'(k * 4), m);
      icc = (k == 1) ? icc & ~m : (k == 2) ? icc | m : icc ^ m;
      rd(OFS_ICC);
      chk("alias result", icc, rv);
    end
    rd(OFS_ICC + 16'h0004);
    chk("alias read response", {30'h0, RESP_SLVERR}, {30'h0, rs});
    chk("alias read data", 32'h0, rv);
    wr(16'h0100, 32'h1);
    chk("unmapped write response", {30'h0, RESP_SLVERR}, {30'h0, rs});
    $display("test aliases done");
    wr(OFS_CONTROL, RUN);
    wr(OFS_POSITION, 32'h0);
    pos = 32'h0;
    repeat (12) begin
      m = $urandom() % 2;
      i_qpc_encoder_model.step(m[0]);
      pos = m[0] ? pos + 1 : pos - 1;
    end
    rd(OFS_POSITION);
    chk("position count", pos, rv);
    wr(OFS_CONTROL, 32'h0);
    steps(3, 1'b1);
    rd(OFS_POSITION);
    chk("stopped position", pos, rv);
    wr(OFS_CONTROL, RUN | 32'h0000_2000);
    @(posedge aclk);
    device_idle <= 1'b1;
    steps(2, 1'b1);
    rd(OFS_POSITION);
    chk("idle position", pos, rv);
    @(posedge aclk);
    device_idle <= 1'b0;
    steps(1, 1'b1);
    pos = pos + 1;
    rd(OFS_POSITION);
    chk("resumed position", pos, rv);
    $display("test counting done");
    // Pass 5 repeats mode 001 with a mismatching phase qualifier; pass 6 is mode 111
    wr(OFS_INDEX, 32'h0);
    for (int k = 0; k < 7; k++) begin
      pm = (k == 5) ? 1 : (k == 6) ? 7 : k;
      icc = $urandom();
      wr(OFS_ICC, icc);
      pos = $urandom();
      wr(OFS_POSITION, pos);
      steps(2, 1'b1);
      pos = pos + 2;
      index_match_value = {pb, pa} ^ ((k == 5) ? 2'h3 : 2'h0);
      wr(OFS_CONTROL, RUN | (32'(pm) << CON_POSITION_INIT_MODE_LSB) | (32'(index_match_value) << CON_IMV_LSB));
      if (pm >= 3) i_qpc_encoder_model.pulse(1'b1);
      repeat ((pm == 4) ? 2 : 1) i_qpc_encoder_model.pulse(1'b0);
      if (k != 5) nidx += (pm == 4) ? 2 : 1;
      if ((k < 5 && pm == 1) || pm == 7) pos = 32'h0;
      else if (k < 5 && pm >= 2) pos = icc;
      rd(OFS_POSITION);
      chk("init mode position", pos, rv);
    end
    rd(OFS_INDEX);
    chk("index count", 32'(nidx), rv);
    icc = pos + 1;
    wr(OFS_ICC, icc);
    wr(OFS_CONTROL, RUN | (32'(PIM_EQ_RESET) << CON_POSITION_INIT_MODE_LSB));
    steps(1, 1'b1);
    rd(OFS_POSITION);
    chk("equal reset position", 32'h0, rv);
    m = $urandom();
    wr(OFS_LOWER_CMP, m);
    wr(OFS_ICC, 32'h0000_0004);
    wr(OFS_CONTROL, RUN | (32'(PIM_MODULO) << CON_POSITION_INIT_MODE_LSB));
    steps(5, 1'b1);
    rd(OFS_POSITION);
    chk("modulo wrap position", m, rv);
    $display("test init_modes done");
    // Mode 01 takes direction from B and ignores polarity; mode 10 gates on B
    for (int j = 1; j < 3; j++) begin
      wr(OFS_CONTROL, 32'h0);
      wr(OFS_POSITION, 32'h0);
      wr(OFS_VELOCITY, 32'h0);
      wr(OFS_CONTROL, RUN | 32'(j) | ((j == 1) ? 32'h0000_0008 : 32'h0000_0004));
      pos = 32'h0;
      for (int k = 0; k < 8; k++) begin
        lv = {pb, pa};
        m = $urandom() % 2;
        i_qpc_encoder_model.step(m[0]);
        if (!lv[0] && pa && j == 1) pos = pb ? pos + 1 : pos - 1;
        else if (!lv[0] && pa && pb) pos = pos + 1;
      end
      rd(OFS_POSITION);
      chk("external clock position", pos, rv);
      rd(OFS_VELOCITY);
      chk("velocity count", pos, rv);
    end
    // Timer gated off by B low: index in mode 001 must not touch it
    while (pb) i_qpc_encoder_model.step(1'b1);
    lv = {pb, pa};
    wr(OFS_POSITION, 32'h0);
    wr(OFS_CONTROL, RUN | 32'(CCM_TIMER) | 32'h0000_0404 | (32'(lv) << CON_IMV_LSB));
    i_qpc_encoder_model.pulse(1'b0);
    rd(OFS_POSITION);
    chk("gated timer position", 32'h0, rv);
    wr(OFS_CONTROL, RUN | 32'(CCM_TIMER));
    wr(OFS_CONTROL, 32'h0);
    rd(OFS_POSITION);
    chk("free timer moved", 32'h1, {31'h0, rv != 32'h0});
    rd(OFS_INTERVAL);
    icc = rv;
    chk("interval timer ran", 32'h1, {31'h0, icc != 32'h0});
    rd(OFS_INTERVAL);
    chk("interval timer stopped", icc, rv);
    $display("test counter_modes done");
    summarize();
  end
endmodule : tb_top
`default_nettype wire
